//--- mie_core.sv
// Instruction decode and execute core of the 8-bit accumulator machine
`timescale 1ns/1ps
// Overview of operation
// - d bit picks accumulator or register destination
// - Carry set on add carry, no borrow
// - Subtract is register plus inverted accumulator
// - Register page spans six-bit address 00-3F
// - Second page accepts addresses 5 to F
// - Third page accepts addresses 0 to F
// - Skip next when tested bit clear
// - Skip next when tested bit set
// - Increment, store, skip on zero result
// - Decrement, store, skip on zero result
// - Sleep clears power-down flag and halts
// - Power-down flag set by reset, watchdog clear
// - Time-out flag set by reset, clear, sleep
// - Watchdog expiry clears time-out flag
// - Computed call pushes, jumps via accumulator
// - Computed jump via accumulator, two cycles
// - Decimal adjust touches only carry
// - Table read uses pointer high, two cycles
// - Three-bit field selects bit position
// - Halt entry clears running watchdog
module mie_core #(
	parameter int unsigned WDT_CYCLES = mie_pkg::WDT_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [mie_pkg::INSTR_W-1:0] instr_word,
	input wire logic [mie_pkg::PCH_W-1:0] table_pointer_high,
	input wire logic [mie_pkg::PCH_W-1:0] pc_high_buffer,
	input wire logic wake_event,
	input wire logic watchdog_enable,
	output logic [mie_pkg::PC_W-1:0] prog_addr,
	output logic [7:0] accumulator_reg,
	output logic zero_flag,
	output logic digit_carry_flag,
	output logic carry_flag,
	output logic power_down_flag_n,
	output logic time_out_flag_n,
	output logic halted,
	output logic [7:0] table_data_high,
	output logic reg_wr_valid,
	output logic [mie_pkg::REG_ADDR_W-1:0] reg_wr_addr,
	output logic [7:0] reg_wr_data,
	output logic watchdog_expired
);
	// Storage pages, plain data, so no reset
	logic [7:0] reg_file [2**mie_pkg::REG_ADDR_W];
	logic [7:0] second_page [2**mie_pkg::PAGE_ADDR_W];
	logic [7:0] third_page [2**mie_pkg::PAGE_ADDR_W];
	logic [mie_pkg::PC_W-1:0] call_stack [mie_pkg::STACK_DEPTH];
	// Sequencer state
	mie_pkg::mie_state_t state, next_state;
	logic [mie_pkg::PC_W-1:0] pc, next_pc, next_addr, pc_inc;
	logic [mie_pkg::SP_W-1:0] sp, next_sp;
	logic [7:0] next_acc, next_tdh;
	logic next_z, next_dc, next_c, next_pd, next_to;
	// Write strobes into the pages and the stack
	logic rf_we, p2_we, p3_we, push, wdt_clr;
	logic [7:0] rf_wd;
	// Instruction fields
	logic [4:0] opc;
	logic [2:0] bsel;
	logic dsel;
	logic [mie_pkg::REG_ADDR_W-1:0] raddr;
	logic [mie_pkg::PAGE_ADDR_W-1:0] paddr;
	logic [7:0] imm, reg_rd, bit_mask, instr_high;
	logic [mie_pkg::PC_W-1:0] acc_target, table_target;
	// Arithmetic unit hookup
	mie_pkg::mie_alu_op_t alu_op;
	logic [7:0] alu_opnd, alu_res;
	logic alu_c, alu_dc, alu_z, upd_z, upd_c, upd_dc;
	logic has_dest, is_skip_step, acc_only, wdt_timeout;
	logic [8:0] sub_ref; // Reference difference for checking
	logic skip_taken;

	// Field split of the fetched word; the register field is six bits
	assign opc = instr_word[mie_pkg::OPC_LSB +: 5];
	assign bsel = instr_word[mie_pkg::BIT_LSB +: 3];
	assign dsel = instr_word[mie_pkg::DEST_POS];
	assign raddr = instr_word[mie_pkg::REG_ADDR_W-1:0];
	assign paddr = instr_word[mie_pkg::PAGE_ADDR_W-1:0];
	assign imm = instr_word[7:0];
	assign instr_high = instr_word[15:8];
	assign reg_rd = reg_file[raddr];
	// Position field picks one of eight bits
	assign bit_mask = 8'h01 << bsel;
	assign acc_target = {pc_high_buffer, accumulator_reg};
	assign table_target = {table_pointer_high, accumulator_reg};
	assign pc_inc = pc + 1'b1;
	assign sub_ref = {1'b0, reg_rd} + {1'b0, ~accumulator_reg} + 9'h001;
	assign has_dest = (opc >= mie_pkg::OP_AND_R) && (opc <= mie_pkg::OP_DEC_SKIP);
	assign is_skip_step = (opc == mie_pkg::OP_INC_SKIP) || (opc == mie_pkg::OP_DEC_SKIP);
	assign acc_only = (opc == mie_pkg::OP_IMM) || (opc == mie_pkg::OP_MISC &&
		(paddr == mie_pkg::SUB_DEC_ADJ || paddr == mie_pkg::SUB_CLR_ACC));
	assign skip_taken = (opc == mie_pkg::OP_SKIP_CLR && !reg_rd[bsel]) ||
		(opc == mie_pkg::OP_SKIP_SET && reg_rd[bsel]) || (is_skip_step && alu_z);

	// Immediate sub-operation decode
	function automatic mie_pkg::mie_alu_op_t mie_imm_op(input logic [2:0] sel);
		case (sel)
			3'h0: mie_imm_op = mie_pkg::ALU_AND;
			3'h1: mie_imm_op = mie_pkg::ALU_OR;
			3'h2: mie_imm_op = mie_pkg::ALU_XOR;
			3'h3: mie_imm_op = mie_pkg::ALU_ADD;
			3'h4: mie_imm_op = mie_pkg::ALU_SUB;
			3'h5: mie_imm_op = mie_pkg::ALU_ADC;
			3'h6: mie_imm_op = mie_pkg::ALU_SBC;
			default: mie_imm_op = mie_pkg::ALU_LOAD;
		endcase
	endfunction

	// Opcode to unit operation
	always_comb begin
		alu_op = mie_pkg::ALU_PASS;
		alu_opnd = reg_rd;
		case (opc)
			mie_pkg::OP_AND_R: alu_op = mie_pkg::ALU_AND;
			mie_pkg::OP_OR_R: alu_op = mie_pkg::ALU_OR;
			mie_pkg::OP_XOR_R: alu_op = mie_pkg::ALU_XOR;
			mie_pkg::OP_ADD_R: alu_op = mie_pkg::ALU_ADD;
			mie_pkg::OP_SUB_R: alu_op = mie_pkg::ALU_SUB;
			mie_pkg::OP_ADC_R: alu_op = mie_pkg::ALU_ADC;
			mie_pkg::OP_SBC_R: alu_op = mie_pkg::ALU_SBC;
			mie_pkg::OP_RR_R: alu_op = mie_pkg::ALU_RR;
			mie_pkg::OP_RL_R: alu_op = mie_pkg::ALU_RL;
			mie_pkg::OP_INC_R, mie_pkg::OP_INC_SKIP: alu_op = mie_pkg::ALU_INC;
			mie_pkg::OP_DEC_R, mie_pkg::OP_DEC_SKIP: alu_op = mie_pkg::ALU_DEC;
			mie_pkg::OP_COM_R: alu_op = mie_pkg::ALU_COM;
			mie_pkg::OP_SWAP_R: alu_op = mie_pkg::ALU_SWAP;
			mie_pkg::OP_IMM: begin
				alu_op = mie_imm_op(bsel);
				alu_opnd = imm;
			end
			mie_pkg::OP_MISC: begin
				if (paddr == mie_pkg::SUB_DEC_ADJ) begin
					alu_op = mie_pkg::ALU_DAA;
				end else begin
					alu_op = mie_pkg::ALU_CLR;
				end
			end
			default: alu_op = mie_pkg::ALU_PASS;
		endcase
	end

	mie_alu u_alu (
		.op(alu_op),
		.opnd(alu_opnd),
		.acc(accumulator_reg),
		.c_in(carry_flag),
		.dc_in(digit_carry_flag),
		.result(alu_res),
		.c_out(alu_c),
		.dc_out(alu_dc),
		.z_out(alu_z),
		.upd_z(upd_z),
		.upd_c(upd_c),
		.upd_dc(upd_dc)
	);

	// Cleared on sleep and watchdog clear
	mie_watchdog #(
		.TIMEOUT_CYCLES(WDT_CYCLES)
	) u_wdt (
		.core_clk(core_clk),
		.rst(rst),
		.enable(watchdog_enable),
		.clear(wdt_clr),
		.timeout(wdt_timeout)
	);
	assign watchdog_expired = wdt_timeout;

	// Next-state logic of the sequencer and the architectural registers
	always_comb begin
		next_state = state;
		next_pc = pc;
		next_addr = prog_addr;
		next_sp = sp;
		next_acc = accumulator_reg;
		next_tdh = table_data_high;
		next_z = zero_flag;
		next_dc = digit_carry_flag;
		next_c = carry_flag;
		next_pd = power_down_flag_n;
		next_to = time_out_flag_n;
		rf_we = 1'b0;
		rf_wd = alu_res;
		p2_we = 1'b0;
		p3_we = 1'b0;
		push = 1'b0;
		wdt_clr = 1'b0;
		case (state)
			mie_pkg::ST_EXEC: begin
				next_pc = pc_inc;
				next_addr = pc_inc;
				// Destination select
				if (has_dest) begin
					if (dsel) begin
						rf_we = 1'b1;
					end else begin
						next_acc = alu_res;
					end
				end
				if (acc_only) begin
					next_acc = alu_res;
				end
				// Flags follow the unit's masks
				if ((has_dest && !is_skip_step) || acc_only) begin
					next_z = upd_z ? alu_z : zero_flag;
					next_c = upd_c ? alu_c : carry_flag;
					next_dc = upd_dc ? alu_dc : digit_carry_flag;
				end
				// Skip flushes the next word
				if (skip_taken) begin
					next_pc = pc + 11'h002;
					next_addr = pc + 11'h002;
					next_state = mie_pkg::ST_FLUSH;
				end
				case (opc)
					mie_pkg::OP_MOV_A_R: begin
						rf_we = 1'b1;
						rf_wd = accumulator_reg;
					end
					mie_pkg::OP_CLR_R: begin
						rf_we = 1'b1;
						rf_wd = 8'h00;
						next_z = 1'b1;
					end
					mie_pkg::OP_BIT_SET: begin
						rf_we = 1'b1;
						rf_wd = reg_rd | bit_mask;
					end
					mie_pkg::OP_BIT_CLR: begin
						rf_we = 1'b1;
						rf_wd = reg_rd & ~bit_mask;
					end
					// Addresses below five are not on the second page
					mie_pkg::OP_WR_PAGE2: p2_we = (paddr >= mie_pkg::SECOND_PAGE_LO);
					mie_pkg::OP_RD_PAGE2: next_acc = (paddr >= mie_pkg::SECOND_PAGE_LO) ? second_page[paddr] : 8'h00;
					// Whole third page usable
					mie_pkg::OP_WR_PAGE3: p3_we = 1'b1;
					mie_pkg::OP_RD_PAGE3: next_acc = third_page[paddr];
					mie_pkg::OP_GOTO, mie_pkg::OP_CALL: begin
						push = (opc == mie_pkg::OP_CALL);
						next_pc = instr_word[mie_pkg::PC_W-1:0];
						next_addr = instr_word[mie_pkg::PC_W-1:0];
						next_state = mie_pkg::ST_FLUSH;
					end
					mie_pkg::OP_MISC: begin
						case (paddr)
							mie_pkg::SUB_SLEEP: begin
								next_pd = 1'b0;
								next_to = 1'b1;
								wdt_clr = 1'b1;
								next_state = mie_pkg::ST_HALT;
							end
							mie_pkg::SUB_WDT_CLEAR: begin
								next_pd = 1'b1;
								next_to = 1'b1;
								wdt_clr = 1'b1;
							end
							mie_pkg::SUB_CALL_ACC, mie_pkg::SUB_JUMP_ACC: begin
								push = (paddr == mie_pkg::SUB_CALL_ACC);
								next_pc = acc_target;
								next_addr = acc_target;
								next_state = mie_pkg::ST_FLUSH;
							end
							mie_pkg::SUB_TABLE: begin
								// Fetch the table word next cycle
								next_addr = table_target;
								next_state = mie_pkg::ST_TABLE;
							end
							mie_pkg::SUB_RETURN: begin
								next_sp = sp - 1'b1;
								next_pc = call_stack[sp - 1'b1];
								next_addr = call_stack[sp - 1'b1];
								next_state = mie_pkg::ST_FLUSH;
							end
							default: next_state = mie_pkg::ST_EXEC;
						endcase
					end
					default: next_state = next_state;
				endcase
				if (push) begin
					next_sp = sp + 1'b1;
				end
			end
			// Discard the word fetched behind a branch or skip
			mie_pkg::ST_FLUSH: next_state = mie_pkg::ST_EXEC;
			mie_pkg::ST_TABLE: begin
				// Low byte to accumulator, high byte held apart
				next_acc = instr_word[7:0];
				next_tdh = instr_high;
				next_addr = pc;
				next_state = mie_pkg::ST_EXEC;
			end
			mie_pkg::ST_HALT: begin
				if (wake_event || wdt_timeout) begin
					next_state = mie_pkg::ST_EXEC;
				end
			end
			default: next_state = mie_pkg::ST_EXEC;
		endcase
		// Expiry beats a clear in the same cycle
		if (wdt_timeout) begin
			next_to = 1'b0;
		end
	end

	// Architectural registers; power-up sets both status flags
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state <= mie_pkg::ST_EXEC;
			pc <= mie_pkg::PC_RST;
			prog_addr <= mie_pkg::PC_RST;
			sp <= '0;
			accumulator_reg <= mie_pkg::ACC_RST;
			table_data_high <= mie_pkg::ACC_RST;
			zero_flag <= mie_pkg::FLAG_RST;
			digit_carry_flag <= mie_pkg::FLAG_RST;
			carry_flag <= mie_pkg::FLAG_RST;
			power_down_flag_n <= mie_pkg::FLAG_N_RST;
			time_out_flag_n <= mie_pkg::FLAG_N_RST;
			halted <= 1'b0;
			reg_wr_valid <= 1'b0;
			reg_wr_addr <= '0;
			reg_wr_data <= 8'h00;
		end else begin
			state <= next_state;
			pc <= next_pc;
			prog_addr <= next_addr;
			sp <= next_sp;
			accumulator_reg <= next_acc;
			table_data_high <= next_tdh;
			zero_flag <= next_z;
			digit_carry_flag <= next_dc;
			carry_flag <= next_c;
			power_down_flag_n <= next_pd;
			time_out_flag_n <= next_to;
			halted <= (next_state == mie_pkg::ST_HALT);
			reg_wr_valid <= rf_we;
			reg_wr_addr <= raddr;
			reg_wr_data <= rf_wd;
		end
	end

	// Page and stack storage writes
	always_ff @(posedge core_clk) begin
		if (rf_we) begin
			reg_file[raddr] <= rf_wd;
		end
		if (p2_we) begin
			second_page[paddr] <= accumulator_reg;
		end
		if (p3_we) begin
			third_page[paddr] <= accumulator_reg;
		end
		if (push) begin
			call_stack[sp] <= pc_inc;
		end
	end

	// Checks on the executed behaviour
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	wire exec = (state == mie_pkg::ST_EXEC);
	sequence seq_two_cycle;
		state == mie_pkg::ST_FLUSH ##1 state == mie_pkg::ST_EXEC;
	endsequence
	AST_DEST_ACC: assert property (exec && has_dest && !dsel |=> accumulator_reg == $past(alu_res) && !reg_wr_valid)
		else $error("accumulator destination not written");
	AST_DEST_REG: assert property (exec && has_dest && dsel |=> reg_wr_valid && reg_wr_addr == $past(raddr))
		else $error("register destination not written");
	AST_SUB_CARRY: assert property (exec && opc == mie_pkg::OP_SUB_R |=> carry_flag == $past(sub_ref[8]))
		else $error("subtract carry wrong");
	AST_SKIP_CLR: assert property (exec && opc == mie_pkg::OP_SKIP_CLR && !reg_rd[bsel] |=> seq_two_cycle)
		else $error("clear-bit skip not taken");
	AST_SKIP_SET: assert property (exec && opc == mie_pkg::OP_SKIP_SET && !reg_rd[bsel] |=> exec)
		else $error("set-bit skip taken on clear bit");
	AST_DEC_SKIP: assert property (exec && opc == mie_pkg::OP_DEC_SKIP && alu_z |=> seq_two_cycle)
		else $error("decrement skip not taken");
	AST_SLEEP: assert property (exec && opc == mie_pkg::OP_MISC && paddr == mie_pkg::SUB_SLEEP
		|=> !power_down_flag_n && halted) else $error("sleep did not halt");
	AST_TIMEOUT: assert property (wdt_timeout |=> !time_out_flag_n)
		else $error("time-out flag not cleared");
	AST_CALL_ACC: assert property (exec && opc == mie_pkg::OP_MISC && paddr == mie_pkg::SUB_CALL_ACC
		|=> prog_addr == $past(acc_target) && sp == $past(sp) + 2'h1 ##1 exec) else $error("computed call wrong");
	AST_TABLE: assert property (exec && opc == mie_pkg::OP_MISC && paddr == mie_pkg::SUB_TABLE
		|=> prog_addr == $past(table_target) ##1 table_data_high == $past(instr_high) && exec)
		else $error("table read wrong");
	AST_PAGE2: assert property (exec && opc == mie_pkg::OP_RD_PAGE2 && paddr < mie_pkg::SECOND_PAGE_LO
		|=> accumulator_reg == 8'h00) else $error("second page below five not zero");
endmodule

//--- mie_pkg.sv
// Shared constants and types for the instruction execution core
package mie_pkg;
	// Widths
	localparam int PC_W = 11;
	localparam int PCH_W = 3;
	localparam int INSTR_W = 16;
	localparam int REG_ADDR_W = 6;
	localparam int PAGE_ADDR_W = 4;
	localparam int STACK_DEPTH = 4;
	localparam int SP_W = 2;
	localparam int WDT_W = 23;
	// Instruction field positions
	localparam int OPC_LSB = 11;
	localparam int BIT_LSB = 8;
	localparam int DEST_POS = 6;
	// Lowest legal second-page address
	localparam logic [3:0] SECOND_PAGE_LO = 4'h5;
	// Reset values
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [10:0] PC_RST = 11'h000;
	localparam logic FLAG_RST = 1'b0;
	localparam logic FLAG_N_RST = 1'b1;
	// Watchdog period, in its own unit, and the clock rate
	localparam int WDT_PERIOD_MS = 18;
	localparam int CLK_KHZ = 250000;
	localparam int unsigned WDT_CYCLES = WDT_PERIOD_MS * CLK_KHZ;
	// Major opcodes, bits 15:11
	localparam logic [4:0] OP_NOP = 5'h00;
	localparam logic [4:0] OP_AND_R = 5'h01;
	localparam logic [4:0] OP_OR_R = 5'h02;
	localparam logic [4:0] OP_XOR_R = 5'h03;
	localparam logic [4:0] OP_ADD_R = 5'h04;
	localparam logic [4:0] OP_SUB_R = 5'h05;
	localparam logic [4:0] OP_ADC_R = 5'h06;
	localparam logic [4:0] OP_SBC_R = 5'h07;
	localparam logic [4:0] OP_RR_R = 5'h08;
	localparam logic [4:0] OP_RL_R = 5'h09;
	localparam logic [4:0] OP_INC_R = 5'h0A;
	localparam logic [4:0] OP_DEC_R = 5'h0B;
	localparam logic [4:0] OP_COM_R = 5'h0C;
	localparam logic [4:0] OP_MOV_R = 5'h0D;
	localparam logic [4:0] OP_SWAP_R = 5'h0E;
	localparam logic [4:0] OP_INC_SKIP = 5'h0F;
	localparam logic [4:0] OP_DEC_SKIP = 5'h10;
	localparam logic [4:0] OP_MOV_A_R = 5'h11;
	localparam logic [4:0] OP_CLR_R = 5'h12;
	localparam logic [4:0] OP_BIT_SET = 5'h13;
	localparam logic [4:0] OP_BIT_CLR = 5'h14;
	localparam logic [4:0] OP_SKIP_CLR = 5'h15;
	localparam logic [4:0] OP_SKIP_SET = 5'h16;
	localparam logic [4:0] OP_IMM = 5'h17;
	localparam logic [4:0] OP_MISC = 5'h18;
	localparam logic [4:0] OP_WR_PAGE2 = 5'h19;
	localparam logic [4:0] OP_RD_PAGE2 = 5'h1A;
	localparam logic [4:0] OP_WR_PAGE3 = 5'h1B;
	localparam logic [4:0] OP_RD_PAGE3 = 5'h1C;
	localparam logic [4:0] OP_GOTO = 5'h1D;
	localparam logic [4:0] OP_CALL = 5'h1E;
	// Miscellaneous sub-opcodes, bits 3:0
	localparam logic [3:0] SUB_SLEEP = 4'h1;
	localparam logic [3:0] SUB_WDT_CLEAR = 4'h2;
	localparam logic [3:0] SUB_DEC_ADJ = 4'h3;
	localparam logic [3:0] SUB_CLR_ACC = 4'h4;
	localparam logic [3:0] SUB_CALL_ACC = 4'h5;
	localparam logic [3:0] SUB_JUMP_ACC = 4'h6;
	localparam logic [3:0] SUB_TABLE = 4'h7;
	localparam logic [3:0] SUB_RETURN = 4'h8;
	// Operations of the arithmetic unit; seventeen of them need five bits
	typedef enum logic [4:0] {ALU_AND, ALU_OR, ALU_XOR, ALU_ADD, ALU_SUB, ALU_ADC, ALU_SBC, ALU_PASS,
		ALU_LOAD, ALU_RR, ALU_RL, ALU_INC, ALU_DEC, ALU_COM, ALU_CLR, ALU_DAA, ALU_SWAP} mie_alu_op_t;
	// Sequencer states
	typedef enum logic [1:0] {ST_EXEC, ST_FLUSH, ST_TABLE, ST_HALT} mie_state_t;
endpackage

//--- mie_alu.sv
// Combinational arithmetic and logic unit with flag results
`timescale 1ns/1ps
module mie_alu (
	input wire mie_pkg::mie_alu_op_t op,
	input wire logic [7:0] opnd,
	input wire logic [7:0] acc,
	input wire logic c_in,
	input wire logic dc_in,
	output logic [7:0] result,
	output logic c_out,
	output logic dc_out,
	output logic z_out,
	output logic upd_z,
	output logic upd_c,
	output logic upd_dc
);
	// One adder serves add, subtract and their carry forms
	always_comb begin
		logic [7:0] addend;
		logic cin;
		logic [8:0] sum;
		logic [4:0] low;
		logic [8:0] adj;
		addend = acc;
		cin = 1'b0;
		// Subtract adds the inverted accumulator
		if (op == mie_pkg::ALU_SUB || op == mie_pkg::ALU_SBC) begin
			addend = ~acc;
		end
		if (op == mie_pkg::ALU_SUB) begin
			cin = 1'b1;
		end else if (op == mie_pkg::ALU_ADC || op == mie_pkg::ALU_SBC) begin
			cin = c_in;
		end
		sum = {1'b0, opnd} + {1'b0, addend} + {8'h00, cin};
		low = {1'b0, opnd[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
		// Packed decimal correction, low nibble first
		adj = {1'b0, acc};
		if (acc[3:0] > 4'h9 || dc_in) begin
			adj = adj + 9'h006;
		end
		if (adj[7:4] > 4'h9 || c_in || adj[8]) begin
			adj = adj + 9'h060;
		end
		result = opnd;
		c_out = c_in;
		dc_out = low[4];
		// Eight of the seventeen operations touch only zero
		upd_z = 1'b1;
		upd_c = 1'b0;
		upd_dc = 1'b0;
		case (op)
			mie_pkg::ALU_AND: result = opnd & acc;
			mie_pkg::ALU_OR: result = opnd | acc;
			mie_pkg::ALU_XOR: result = opnd ^ acc;
			mie_pkg::ALU_ADD, mie_pkg::ALU_SUB, mie_pkg::ALU_ADC, mie_pkg::ALU_SBC: begin
				// Carry out doubles as not-borrow
				result = sum[7:0];
				c_out = sum[8];
				upd_c = 1'b1;
				upd_dc = 1'b1;
			end
			mie_pkg::ALU_RR: begin
				// Bit shifted out lands in carry
				result = {c_in, opnd[7:1]};
				c_out = opnd[0];
				upd_c = 1'b1;
				upd_z = 1'b0;
			end
			mie_pkg::ALU_RL: begin
				result = {opnd[6:0], c_in};
				c_out = opnd[7];
				upd_c = 1'b1;
				upd_z = 1'b0;
			end
			mie_pkg::ALU_INC: result = opnd + 8'h01;
			mie_pkg::ALU_DEC: result = opnd - 8'h01;
			mie_pkg::ALU_COM: result = ~opnd;
			mie_pkg::ALU_CLR: result = 8'h00;
			mie_pkg::ALU_DAA: begin
				result = adj[7:0];
				c_out = adj[8] | c_in;
				upd_c = 1'b1;
				upd_z = 1'b0;
			end
			mie_pkg::ALU_SWAP: begin
				result = {opnd[3:0], opnd[7:4]};
				upd_z = 1'b0;
			end
			mie_pkg::ALU_LOAD: upd_z = 1'b0;
			default: result = opnd;
		endcase
		z_out = (result == 8'h00);
	end
endmodule

//--- mie_watchdog.sv
// Free-running watchdog counter with clear and expiry pulse
`timescale 1ns/1ps
module mie_watchdog #(
	parameter int unsigned TIMEOUT_CYCLES = mie_pkg::WDT_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic enable,
	input wire logic clear,
	output logic timeout
);
	// Terminal count, one below the period
	localparam logic [mie_pkg::WDT_W-1:0] LAST = (mie_pkg::WDT_W)'(TIMEOUT_CYCLES - 1);
	logic [mie_pkg::WDT_W-1:0] watchdog_counter; // Cycles since last clear
	logic [mie_pkg::WDT_W-1:0] next_count;
	logic next_timeout;
	// Clear restarts from zero but never stops the count
	always_comb begin
		next_count = watchdog_counter;
		next_timeout = 1'b0;
		if (clear) begin
			next_count = '0;
		end else if (enable) begin
			if (watchdog_counter == LAST) begin
				next_count = '0;
				next_timeout = 1'b1;
			end else begin
				next_count = watchdog_counter + 1'b1;
			end
		end
	end
	// Counter and expiry pulse
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			watchdog_counter <= '0;
			timeout <= 1'b0;
		end else begin
			watchdog_counter <= next_count;
			timeout <= next_timeout;
		end
	end
endmodule

//--- mcu_instruction_execution_tb_top.sv
// Self-checking random testbench for the instruction execution core
`timescale 1ns/1ps
module mcu_instruction_execution_tb_top;
	logic core_clk = 1'b0; // 250 MHz core clock
	logic rst = 1'b1; // Held for four cycles
	logic [15:0] instr_word = 16'h0000; // Nop when idle
	logic [2:0] table_pointer_high = 3'h0;
	logic [2:0] pc_high_buffer = 3'h0;
	logic wake_event = 1'b0;
	logic watchdog_enable = 1'b0; // Off until the watchdog tests, so expiry cannot disturb them
	logic [10:0] prog_addr, p0, p1;
	logic [7:0] accumulator_reg, table_data_high, reg_wr_data, a, r, v, ex, b;
	logic zero_flag, digit_carry_flag, carry_flag, power_down_flag_n, time_out_flag_n, halted;
	logic reg_wr_valid, watchdog_expired, d, ec, ez, edc, ci;
	logic [5:0] reg_wr_addr, ad;
	logic [8:0] s;
	logic [15:0] f;
	logic [4:0] op;
	logic [4:0] ops [9] = '{mie_pkg::OP_AND_R, mie_pkg::OP_OR_R, mie_pkg::OP_XOR_R, mie_pkg::OP_ADD_R,
		mie_pkg::OP_SUB_R, mie_pkg::OP_ADC_R, mie_pkg::OP_SBC_R, mie_pkg::OP_RR_R, mie_pkg::OP_RL_R};
	logic [7:0] sv [3] = '{8'hFF, 8'h00, 8'h5A}; // Wrap, zero and plain values
	int n_fail = 0, check_count = 0, seed = 90, n;
	// Short watchdog period keeps the run brief
	mie_core #(.WDT_CYCLES(50)) mie_core_i (.core_clk, .rst, .instr_word, .table_pointer_high, .pc_high_buffer,
		.wake_event, .watchdog_enable, .prog_addr, .accumulator_reg, .zero_flag, .digit_carry_flag, .carry_flag,
		.power_down_flag_n, .time_out_flag_n, .halted, .table_data_high, .reg_wr_valid, .reg_wr_addr, .reg_wr_data,
		.watchdog_expired);
	always #2 core_clk = ~core_clk;
	// Register-operand word
	function automatic logic [15:0] ins(logic [4:0] o, logic [2:0] bt, logic dd, logic [5:0] ra);
		return {o, bt, 1'b0, dd, ra};
	endfunction
	// Page or miscellaneous word
	function automatic logic [15:0] pg(logic [4:0] o, logic [3:0] sub);
		return {o, 7'h00, sub};
	endfunction
	// Expected result and flags; carry state is tracked here, never read back
	function automatic void model(logic [4:0] o);
		b = (o == ops[4] || o == ops[6]) ? ~a : a;
		ci = (o == ops[3]) ? 1'b0 : (o == ops[4]) ? 1'b1 : ec;
		s = r + b + ci;
		ex = s[7:0];
		case (o)
			ops[0]: ex = a & r;
			ops[1]: ex = a | r;
			ops[2]: ex = a ^ r;
			ops[7]: {ex, ec} = {ec, r};
			ops[8]: {ec, ex} = {r, ec};
			default: begin
				ec = s[8];
				edc = (r[3:0] + b[3:0] + ci) > 5'h0F;
			end
		endcase
		if (o != ops[7] && o != ops[8]) ez = (ex == 8'h00);
	endfunction
	task automatic chk(logic [15:0] g, logic [15:0] e);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	// One instruction, then a follower word; p1 is the fetch address after it
	task automatic exe(logic [15:0] w, logic [15:0] fw);
		@(negedge core_clk) p0 = prog_addr;
		@(posedge core_clk) instr_word <= w;
		@(posedge core_clk) instr_word <= fw;
		@(negedge core_clk) p1 = prog_addr;
	endtask
	task automatic ld(logic [7:0] val);
		exe({mie_pkg::OP_IMM, 3'h7, val}, 16'h0000);
	endtask
	// Bounded wait for the expiry pulse
	task automatic wexp();
		n = 0;
		while (watchdog_expired !== 1'b1 && n < 200) begin
			@(negedge core_clk);
			n++;
		end
	endtask
	task automatic summarize();
		if (n_fail == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		{ec, ez, edc} = 3'h0;
		repeat (3) @(posedge core_clk);
		@(negedge core_clk) chk({power_down_flag_n, time_out_flag_n, halted, zero_flag, digit_carry_flag,
			carry_flag, accumulator_reg}, 16'h3000);
		@(posedge core_clk) rst <= 1'b0;
		// Random arithmetic, logic and rotates on random registers
		repeat (40) begin
			a = 8'($random(seed));
			r = 8'($random(seed));
			ad = 6'($random(seed));
			d = 1'($random(seed));
			op = ops[$unsigned($random(seed)) % 9];
			ld(r);
			exe(ins(mie_pkg::OP_MOV_A_R, 3'h0, 1'b1, ad), 16'h0000);
			ld(a);
			exe(ins(op, 3'h0, d, ad), 16'h0000);
			model(op);
			chk({reg_wr_valid, accumulator_reg}, {d, d ? a : ex});
			if (d) chk({reg_wr_addr, reg_wr_data}, {ad, ex});
			chk({zero_flag, digit_carry_flag, carry_flag}, {ez, edc, ec});
		end
		// Bit tests at every position: skip adds one fetch step
		for (int i = 0; i < 8; i++) begin
			v = 8'($random(seed));
			ld(v);
			exe(ins(mie_pkg::OP_MOV_A_R, 3'h0, 1'b1, 6'h3F), 16'h0000);
			exe(ins(mie_pkg::OP_SKIP_CLR, 3'(i), 1'b0, 6'h3F), 16'h0000);
			chk(p1 - p0, v[i] ? 16'h0002 : 16'h0003);
			exe(ins(mie_pkg::OP_SKIP_SET, 3'(i), 1'b0, 6'h3F), 16'h0000);
			chk(p1 - p0, v[i] ? 16'h0003 : 16'h0002);
		end
		foreach (sv[j]) begin
			ld(sv[j]);
			exe(ins(mie_pkg::OP_MOV_A_R, 3'h0, 1'b1, 6'h10), 16'h0000);
			exe(ins(mie_pkg::OP_INC_SKIP, 3'h0, 1'b1, 6'h10), 16'h0000);
			chk({reg_wr_data, 5'(p1 - p0)}, {sv[j] + 8'h01, sv[j] == 8'hFF ? 5'h03 : 5'h02});
			exe(ins(mie_pkg::OP_DEC_SKIP, 3'h0, 1'b0, 6'h10), 16'h0000);
			chk({accumulator_reg, 5'(p1 - p0)}, {sv[j], sv[j] == 8'h00 ? 5'h03 : 5'h02});
		end
		// Both special pages at every address; low second-page addresses are absent
		for (int i = 0; i < 16; i++) begin
			v = 8'($random(seed));
			ld(v);
			exe(pg(mie_pkg::OP_WR_PAGE2, 4'(i)), 16'h0000);
			ld(~v);
			exe(pg(mie_pkg::OP_WR_PAGE3, 4'(i)), 16'h0000);
			exe(pg(mie_pkg::OP_RD_PAGE2, 4'(i)), 16'h0000);
			chk({accumulator_reg, 5'(p1 - p0)}, {i < 5 ? 8'h00 : v, 5'h02});
			exe(pg(mie_pkg::OP_RD_PAGE3, 4'(i)), 16'h0000);
			chk({accumulator_reg, 5'(p1 - p0)}, {~v, 5'h02});
		end
		// Computed call then computed jump
		for (int j = 0; j < 2; j++) begin
			@(posedge core_clk) pc_high_buffer <= 3'($random(seed));
			v = 8'($random(seed));
			ld(v);
			exe(pg(mie_pkg::OP_MISC, j ? mie_pkg::SUB_JUMP_ACC : mie_pkg::SUB_CALL_ACC), 16'h0000);
			chk(p1, {pc_high_buffer, v});
			// Return lands just past the call, so the pushed address was right
			if (j == 0) begin
				f = {5'h00, p0 + 11'h002};
				exe(pg(mie_pkg::OP_MISC, mie_pkg::SUB_RETURN), 16'h0000);
				chk(p1, f);
			end
		end
		// Table read; follower word has a nop opcode since it also gets fetched
		@(posedge core_clk) table_pointer_high <= 3'($random(seed));
		v = 8'($random(seed));
		f = {5'h00, 11'($random(seed))};
		ld(v);
		exe(pg(mie_pkg::OP_MISC, mie_pkg::SUB_TABLE), f);
		chk(p1, {table_pointer_high, v});
		@(negedge core_clk) chk({table_data_high, accumulator_reg}, f);
		chk(prog_addr, p0 + 11'h002);
		// Decimal adjust after 99 + 99 keeps zero and digit carry
		ld(8'h99);
		exe({mie_pkg::OP_IMM, 3'h3, 8'h99}, 16'h0000);
		exe(pg(mie_pkg::OP_MISC, mie_pkg::SUB_DEC_ADJ), 16'h0000);
		chk({accumulator_reg, zero_flag, digit_carry_flag, carry_flag}, 11'h4C3);
		// Watchdog expiry, clear, sleep and wake-up
		@(posedge core_clk) watchdog_enable <= 1'b1;
		wexp();
		@(negedge core_clk) chk(time_out_flag_n, 1'b0);
		exe(pg(mie_pkg::OP_MISC, mie_pkg::SUB_WDT_CLEAR), 16'h0000);
		chk({power_down_flag_n, time_out_flag_n}, 2'h3);
		exe(pg(mie_pkg::OP_MISC, mie_pkg::SUB_SLEEP), 16'h0000);
		chk({power_down_flag_n, time_out_flag_n, halted}, 3'h3);
		wexp();
		chk(n > 45 && n < 55, 1'b1);
		@(negedge core_clk) chk({halted, time_out_flag_n}, 2'h0);
		exe(pg(mie_pkg::OP_MISC, mie_pkg::SUB_SLEEP), 16'h0000);
		chk(halted, 1'b1);
		@(posedge core_clk) wake_event <= 1'b1;
		@(posedge core_clk) wake_event <= 1'b0;
		@(negedge core_clk) chk(halted, 1'b0);
		summarize();
	end
	// Whole run needs well under 5000 cycles; 50000 means a hang
	initial begin
		#200000;
		n_fail++;
		summarize();
	end
endmodule
